/* sas_analog_model.sv */
// Analog side model: input mux, sample-and-hold and comparator.
`default_nettype none
module sas_analog_model (
  input  wire logic        core_clk,
  input  wire logic [79:0] pin_level,
  input  wire logic [2:0]  ana_chan_sel,
  input  wire logic        ana_sample,
  input  wire logic [9:0]  dac_code,
  input  wire logic        adc_power_en,
  output var  logic        comp_hi_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held_q = 10'h000;
  logic       junk_q = 1'b0;
  // The pins are only read, never driven, as analog inputs must be.
  // Tracks the selected pin while sampling and holds it for the trials.
  always @(posedge core_clk) begin
    if (ana_sample) held_q <= pin_level[ana_chan_sel*10 +: 10];
    junk_q <= ~junk_q;
  end
  // An unpowered comparator gives no useful answer, so it toggles.
  assign comp_hi_in = adc_power_en ? (held_q >= dac_code) : junk_q;
endmodule
`default_nettype wire

/* sas_defines.svh */
// Register map, field positions, reset values and cycle counts of the converter sequencer.
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

// Byte addresses of the word-aligned registers.
`define SAS_ADDR_CTRL    8'h00
`define SAS_ADDR_RES_HI  8'h04
`define SAS_ADDR_RES_LO  8'h08
`define SAS_ADDR_AUX     8'h0c
`define SAS_ADDR_PWR     8'h10
`define SAS_ADDR_STAT    8'h14
`define SAS_ADDR_MASK    8'h18

// Field positions in the conversion control register.
`define SAS_CTRL_PWR     7
`define SAS_CTRL_SPD_HI  6
`define SAS_CTRL_SPD_LO  5
`define SAS_CTRL_DONE    4
`define SAS_CTRL_START   3
`define SAS_CTRL_CHS_HI  2

// Field positions in the auxiliary and power control registers.
`define SAS_AUX_CONV_IE  4
`define SAS_PWR_IDLE     0
`define SAS_PWR_PD       1

// Event bits of the interrupt status register.
`define SAS_EV_DONE      0
`define SAS_EV_REFUSED   1
`define SAS_EV_ABORT     2
`define SAS_NUM_EV       3

// Reset values.
`define SAS_CTRL_RST     8'h00
`define SAS_AUX_RST      8'h00
`define SAS_PWR_RST      2'h0
`define SAS_MASK_RST     3'h0

// Conversion lengths in clock cycles for each speed code.
`define SAS_CYC_SPD0     11'd1080
`define SAS_CYC_SPD1     11'd810
`define SAS_CYC_SPD2     11'd540
`define SAS_CYC_SPD3     11'd270

// Result width and the interrupt service vector.
`define SAS_RES_BITS     10
`define SAS_IRQ_VEC      8'h2b

`endif

/* sas_irq.sv */
// Sticky event status with write-one-to-clear, mask and one level interrupt.
`default_nettype none
module sas_irq #(
  parameter int N = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] event_i,
  input  wire logic [N-1:0] clr_i,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] mask_i,
  output var  logic [N-1:0] status_q,
  output var  logic [N-1:0] mask_q,
  output var  logic         irq_q
);
  logic [N-1:0] status_d;
  logic [N-1:0] mask_d;
  logic         irq_d;

  // Per bit, a new event wins over a clear in the same cycle.
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign status_d[i] = event_i[i] | (status_q[i] & ~clr_i[i]);
  end

  // Mask update and interrupt level from the next status.
  always_comb begin
    mask_d = mask_wr ? mask_i : mask_q;
    irq_d  = |(status_d & mask_d);
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      mask_q   <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end
endmodule
`default_nettype wire

/* sas_monitor.sv */
// Concurrent checks on the converter sequencer ports, bound to the top.
`default_nettype none
module sas_monitor (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        serial_periph_irq_enable,
  input wire logic        ana_sample,
  input wire logic [9:0]  dac_code,
  input wire logic        adc_power_en,
  input wire logic        cpu_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        conv_irq_req,
  input wire logic [7:0]  conv_irq_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] smp_q;
  logic [9:0] smp_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Counts the cycles spent in the sampling phase.
  always_comb smp_d = ana_sample ? smp_q + 10'h001 : 10'h000;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) smp_q <= 10'h000;
    else smp_q <= smp_d;
  end
  // Sampling ends, then the first trial tries the top bit.
  sequence s_smp_end;
    $fell(ana_sample) && adc_power_en;
  endsequence
  sequence s_msb_try;
    ##[0:2] dac_code == 10'h200;
  endsequence
  ack_resp_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no acknowledge one cycle after a request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("acknowledge longer than one cycle");
  unmapped_zero_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i > 8'h18)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  sample_len_a: assert property (s_smp_end |-> smp_q inside {10'h10e, 10'h0ca, 10'h087, 10'h043})
    else $error("sampling phase has a wrong length");
  msb_first_a: assert property (s_smp_end |-> s_msb_try) else $error("first trial is not the top bit");
  idle_gate_a: assert property (!cpu_clk_en |-> !adc_power_en) else $error("converter powered in idle");
  pd_gate_a: assert property (!periph_clk_en |-> !cpu_clk_en)
    else $error("processor clock runs in power-down");
  irq_share_a: assert property (conv_irq_req |-> $past(serial_periph_irq_enable))
    else $error("request without shared enable");
  vector_a: assert property (conv_irq_vector == 8'h2b) else $error("wrong service vector");
  power_first_a: assert property ($rose(ana_sample) |-> ##[0:1] adc_power_en)
    else $error("sampling without power");
endmodule
bind sas_top sas_monitor u_mon (
  .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_periph_irq_enable(serial_periph_irq_enable), .ana_sample(ana_sample), .dac_code(dac_code),
  .adc_power_en(adc_power_en), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
  .conv_irq_req(conv_irq_req), .conv_irq_vector(conv_irq_vector)
);
`default_nettype wire

/* sas_pkg.sv */
// Types shared by the converter sequencer modules.
`default_nettype none
package sas_pkg;
  // Phases of one conversion.
  typedef enum logic [1:0] {
    SAS_IDLE   = 2'b00,
    SAS_SAMPLE = 2'b01,
    SAS_STEP   = 2'b10,
    SAS_TAIL   = 2'b11
  } sas_eng_state_t;

  // Conversion speed code.
  typedef logic [1:0] sas_speed_t;
endpackage
`default_nettype wire

/* sas_sar_engine.sv */
// Successive-approximation step engine: sampling phase, bit trials and end of conversion.
`default_nettype none
module sas_sar_engine #(
  parameter int RES_W = 10
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     start,
  input  wire logic                     abort,
  input  wire logic [10:0]              total_len,
  input  wire logic                     comp_hi,
  output var  logic                     busy_q,
  output var  logic                     sampling_q,
  output var  logic [RES_W-1:0]         dac_q,
  output var  logic [RES_W-1:0]         result_q,
  output var  logic                     done_q
);
  import sas_pkg::*;

  localparam int BW = $clog2(RES_W);

  sas_eng_state_t   state_q, state_d;
  logic [10:0]      tot_q, tot_d;
  logic [10:0]      len_q, len_d;
  logic [10:0]      step_q, step_d;
  logic [BW-1:0]    bit_q, bit_d;
  logic [RES_W-1:0] dac_d, result_d, kept;
  logic             busy_d, sampling_d, done_d;
  logic [10:0]      samp_len, step_len;

  // A quarter of the length samples; the bit trials share the rest in whole steps, and the leftover cycles run in the tail.
  always_comb begin
    samp_len = len_q >> 2;
    step_len = 11'((len_q - samp_len - 11'd1) / 11'(RES_W));
  end

  // Next-state logic of the conversion sequence.
  always_comb begin
    state_d    = state_q;
    tot_d      = tot_q;
    len_d      = len_q;
    step_d     = step_q;
    bit_d      = bit_q;
    dac_d      = dac_q;
    result_d   = result_q;
    busy_d     = busy_q;
    sampling_d = sampling_q;
    done_d     = 1'b0;
    kept       = dac_q;
    if (state_q != SAS_IDLE) begin
      tot_d = tot_q + 11'd1;
    end
    case (state_q)
      SAS_IDLE: begin
        if (start) begin
          state_d    = SAS_SAMPLE;
          tot_d      = '0;
          len_d      = total_len;
          dac_d      = '0;
          busy_d     = 1'b1;
          sampling_d = 1'b1;
        end
      end
      SAS_SAMPLE: begin
        if (tot_q == samp_len - 11'd1) begin
          state_d    = SAS_STEP;
          sampling_d = 1'b0;
          step_d     = '0;
          bit_d      = BW'(RES_W - 1);
          dac_d      = RES_W'(1) << (RES_W - 1);
        end
      end
      SAS_STEP: begin
        step_d = step_q + 11'd1;
        if (step_q == step_len - 11'd1) begin
          step_d = '0;
          if (!comp_hi) begin
            kept[bit_q] = 1'b0;
          end
          if (bit_q == '0) begin
            dac_d   = kept;
            state_d = SAS_TAIL;
          end else begin
            dac_d = kept | (RES_W'(1) << (bit_q - BW'(1)));
            bit_d = bit_q - BW'(1);
          end
        end
      end
      SAS_TAIL: begin
        if (tot_q == len_q - 11'd1) begin
          state_d  = SAS_IDLE;
          result_d = dac_q;
          busy_d   = 1'b0;
          done_d   = 1'b1;
        end
      end
      default: begin
        state_d = SAS_IDLE;
      end
    endcase
    if (abort) begin
      state_d    = SAS_IDLE;
      busy_d     = 1'b0;
      sampling_d = 1'b0;
      done_d     = 1'b0;
    end
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= SAS_IDLE;
      tot_q      <= '0;
      len_q      <= '0;
      step_q     <= '0;
      bit_q      <= '0;
      dac_q      <= '0;
      result_q   <= '0;
      busy_q     <= 1'b0;
      sampling_q <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      tot_q      <= tot_d;
      len_q      <= len_d;
      step_q     <= step_d;
      bit_q      <= bit_d;
      dac_q      <= dac_d;
      result_q   <= result_d;
      busy_q     <= busy_d;
      sampling_q <= sampling_d;
      done_q     <= done_d;
    end
  end
endmodule
`default_nettype wire

/* sas_top.sv */
// Converter sequencer top: Wishbone registers, power gating, start control and results.
//
// Added by the designer: the register offsets and the Wishbone slave port.
`include "sas_defines.svh"
`default_nettype none

// Notes on behaviour
// - Writing a one to the start bit begins a conversion.
// - The start bit clears itself when the conversion it began has finished.
// - The done flag is set by a finished conversion and only software clears it.
// - The speed code picks 1080, 810, 540 or 270 cycles for a whole conversion.
// - About the first quarter of a conversion samples, the rest runs the bit trials.
// - The channel code routes one of eight pins, code 0 for pin 0 up to code 7 for pin 7.
// - The upper eight result bits go to the high register and the lowest two to the low register.
// - The converter interrupt uses service vector 2b hex.
// - Converter power is removed while the chip is in idle or power-down mode.
// - The power bit switches the converter off when clear and on when set.
// - Setting the idle bit stops the processor clock while peripheral clocks keep running.
module sas_top (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        comp_hi_in,
  input  wire logic        serial_periph_irq_enable,
  input  wire logic        wake_event,
  output var  logic [2:0]  ana_chan_sel,
  output var  logic        ana_sample,
  output var  logic [9:0]  dac_code,
  output var  logic        adc_power_en,
  output var  logic        cpu_clk_en,
  output var  logic        periph_clk_en,
  output var  logic        conv_irq_req,
  output var  logic [7:0]  conv_irq_vector,
  output var  logic        irq
);
  import sas_pkg::*;

  localparam int RES_W = `SAS_RES_BITS;
  localparam int NEV   = `SAS_NUM_EV;

  // Reset synchroniser and comparator synchroniser.
  logic [1:0]       rst_sync_q;
  logic             rst_n;
  logic             comp_meta_q;
  logic             comp_sync_q;

  // Bus slave state.
  logic             ack_q, ack_d;
  logic [31:0]      rdat_q, rdat_d;
  logic             req;
  logic             wr;
  logic             wr_ctrl;
  logic             wr_aux;
  logic             wr_pwr;
  logic             wr_stat;
  logic             wr_mask;
  logic [7:0]       wbyte;

  // Control and configuration state.
  logic             power_on_q, power_on_d;
  sas_speed_t       speed_q, speed_d;
  logic             done_flag_q, done_flag_d;
  logic             start_q, start_d;
  logic [2:0]       chs_q, chs_d;
  logic             conv_ie_q, conv_ie_d;
  logic             idle_q, idle_d;
  logic             pd_q, pd_d;
  logic [7:0]       res_hi_q, res_hi_d;
  logic [1:0]       res_lo_q, res_lo_d;
  logic             adc_pwr_q, adc_pwr_d;
  logic             cpu_en_q, cpu_en_d;
  logic             per_en_q, per_en_d;
  logic             conv_irq_q, conv_irq_d;
  logic [7:0]       vec_q;

  // Engine handshake and events.
  logic             start_pulse;
  logic             refused;
  logic             abort;
  logic [10:0]      total_len;
  logic             eng_busy;
  logic             eng_sampling;
  logic [RES_W-1:0] eng_dac;
  logic [RES_W-1:0] eng_result;
  logic             eng_done;
  logic [NEV-1:0]   events;
  logic [NEV-1:0]   stat_clr;
  logic [NEV-1:0]   stat_q;
  logic [NEV-1:0]   mask_q;
  logic             irq_q;

  // Release of the reset passes two flip-flops; the copy drives the whole block.
  // Assertion stays asynchronous; only release is timed.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // The comparator output is asynchronous and passes two flip-flops.
  // Only the second stage feeds the bit trials.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comp_hi_in;
      comp_sync_q <= comp_meta_q;
    end
  end

  // Request decode; writes need byte lane 0, where every register sits.
  // The ack term stops a held request being taken twice.
  always_comb begin
    req     = wb_cyc_i & wb_stb_i & ~ack_q;
    wr      = req & wb_we_i & wb_sel_i[0];
    wbyte   = wb_dat_i[7:0];
    wr_ctrl = wr & (wb_adr_i == `SAS_ADDR_CTRL);
    wr_aux  = wr & (wb_adr_i == `SAS_ADDR_AUX);
    wr_pwr  = wr & (wb_adr_i == `SAS_ADDR_PWR);
    wr_stat = wr & (wb_adr_i == `SAS_ADDR_STAT);
    wr_mask = wr & (wb_adr_i == `SAS_ADDR_MASK);
  end

  // Acknowledge one cycle after the request and capture read data; unmapped reads return zero.
  always_comb begin
    ack_d  = req;
    rdat_d = rdat_q;
    if (req) begin
      rdat_d = '0;
      case (wb_adr_i)
        `SAS_ADDR_CTRL:   rdat_d[7:0] = {power_on_q, speed_q, done_flag_q, start_q, chs_q};
        `SAS_ADDR_RES_HI: rdat_d[7:0] = res_hi_q;
        `SAS_ADDR_RES_LO: rdat_d[1:0] = res_lo_q;
        `SAS_ADDR_AUX:    rdat_d[`SAS_AUX_CONV_IE] = conv_ie_q;
        `SAS_ADDR_PWR:    rdat_d[1:0] = {pd_q, idle_q};
        `SAS_ADDR_STAT:   rdat_d[NEV-1:0] = stat_q;
        `SAS_ADDR_MASK:   rdat_d[NEV-1:0] = mask_q;
        default:          rdat_d = '0;
      endcase
    end
  end

  // Bus slave registers.
  // Read data holds until the next request.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Start acceptance: only when idle, powered and outside the low-power modes.
  // A refused start still writes the other fields.
  always_comb begin
    start_pulse = wr_ctrl & wbyte[`SAS_CTRL_START] & ~start_q & ~eng_busy & wbyte[`SAS_CTRL_PWR]
                  & ~idle_q & ~pd_q;
    refused     = wr_ctrl & wbyte[`SAS_CTRL_START] & ~start_pulse;
    abort       = start_q & ~adc_pwr_d;
  end

  // Conversion length from the speed code.
  // The engine latches it at start.
  always_comb begin
    case (speed_d)
      2'h0:    total_len = `SAS_CYC_SPD0;
      2'h1:    total_len = `SAS_CYC_SPD1;
      2'h2:    total_len = `SAS_CYC_SPD2;
      2'h3:    total_len = `SAS_CYC_SPD3;
      default: total_len = `SAS_CYC_SPD0;
    endcase
  end

  // Conversion control register and the auxiliary enable.
  // A finishing conversion beats a written zero.
  always_comb begin
    power_on_d  = power_on_q;
    speed_d     = speed_q;
    chs_d       = chs_q;
    conv_ie_d   = conv_ie_q;
    done_flag_d = done_flag_q;
    if (wr_ctrl) begin
      power_on_d  = wbyte[`SAS_CTRL_PWR];
      speed_d     = wbyte[`SAS_CTRL_SPD_HI:`SAS_CTRL_SPD_LO];
      chs_d       = wbyte[`SAS_CTRL_CHS_HI:0];
      done_flag_d = wbyte[`SAS_CTRL_DONE];
    end
    if (eng_done) begin
      done_flag_d = 1'b1;
    end
    if (wr_aux) begin
      conv_ie_d = wbyte[`SAS_AUX_CONV_IE];
    end
  end

  // The start bit follows the running conversion and drops when it ends.
  // An abort drops it too, with no done flag.
  always_comb begin
    start_d = start_q;
    if (start_pulse) begin
      start_d = 1'b1;
    end else if (eng_done | abort) begin
      start_d = 1'b0;
    end
  end

  // Result registers load on completion.
  // Both halves load on the same edge.
  always_comb begin
    res_hi_d = res_hi_q;
    res_lo_d = res_lo_q;
    if (eng_done) begin
      res_hi_d = eng_result[RES_W-1:RES_W-8];
      res_lo_d = eng_result[1:0];
    end
  end

  // Power modes; a wake event ends them unless software sets the bit in the same cycle.
  // Losing power while busy aborts the conversion.
  always_comb begin
    idle_d = idle_q;
    pd_d   = pd_q;
    if (wake_event) begin
      idle_d = 1'b0;
      pd_d   = 1'b0;
    end
    if (wr_pwr) begin
      idle_d = wbyte[`SAS_PWR_IDLE] | (idle_d & ~wake_event);
      pd_d   = wbyte[`SAS_PWR_PD] | (pd_d & ~wake_event);
    end
    adc_pwr_d = power_on_d & ~idle_d & ~pd_d;
    cpu_en_d  = ~idle_d & ~pd_d;
    per_en_d  = ~pd_d;
    conv_irq_d = done_flag_d & conv_ie_d & serial_periph_irq_enable;
  end

  // Control, result and power registers.
  // Clock enables reset high so the core runs.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_on_q  <= 1'(`SAS_CTRL_RST >> `SAS_CTRL_PWR);
      speed_q     <= '0;
      chs_q       <= '0;
      done_flag_q <= 1'b0;
      start_q     <= 1'b0;
      conv_ie_q   <= 1'b0;
      idle_q      <= 1'b0;
      pd_q        <= 1'b0;
      res_hi_q    <= '0;
      res_lo_q    <= '0;
      adc_pwr_q   <= 1'b0;
      cpu_en_q    <= 1'b1;
      per_en_q    <= 1'b1;
      conv_irq_q  <= 1'b0;
      vec_q       <= `SAS_IRQ_VEC;
    end else begin
      power_on_q  <= power_on_d;
      speed_q     <= speed_d;
      chs_q       <= chs_d;
      done_flag_q <= done_flag_d;
      start_q     <= start_d;
      conv_ie_q   <= conv_ie_d;
      idle_q      <= idle_d;
      pd_q        <= pd_d;
      res_hi_q    <= res_hi_d;
      res_lo_q    <= res_lo_d;
      adc_pwr_q   <= adc_pwr_d;
      cpu_en_q    <= cpu_en_d;
      per_en_q    <= per_en_d;
      conv_irq_q  <= conv_irq_d;
      vec_q       <= `SAS_IRQ_VEC;
    end
  end

  // Bit trials against the synchronised comparator.
  sas_sar_engine #(
    .RES_W (RES_W)
  ) u_engine (
    .clk        (core_clk),
    .rst_n      (rst_n),
    .start      (start_pulse),
    .abort      (abort),
    .total_len  (total_len),
    .comp_hi    (comp_sync_q),
    .busy_q     (eng_busy),
    .sampling_q (eng_sampling),
    .dac_q      (eng_dac),
    .result_q   (eng_result),
    .done_q     (eng_done)
  );

  // Events for the sticky status register; a one written clears a bit.
  // A new event wins over a clear in one cycle.
  always_comb begin
    events                  = '0;
    events[`SAS_EV_DONE]    = eng_done;
    events[`SAS_EV_REFUSED] = refused;
    events[`SAS_EV_ABORT]   = abort;
    stat_clr                = wr_stat ? wbyte[NEV-1:0] : '0;
  end

  sas_irq #(
    .N (NEV)
  ) u_irq (
    .clk      (core_clk),
    .rst_n    (rst_n),
    .event_i  (events),
    .clr_i    (stat_clr),
    .mask_wr  (wr_mask),
    .mask_i   (wbyte[NEV-1:0]),
    .status_q (stat_q),
    .mask_q   (mask_q),
    .irq_q    (irq_q)
  );

  // Outputs come straight from flip-flops.
  assign wb_dat_o        = rdat_q;
  assign wb_ack_o        = ack_q;
  assign ana_chan_sel    = chs_q;
  assign ana_sample      = eng_sampling;
  assign dac_code        = eng_dac;
  assign adc_power_en    = adc_pwr_q;
  assign cpu_clk_en      = cpu_en_q;
  assign periph_clk_en   = per_en_q;
  assign conv_irq_req    = conv_irq_q;
  assign conv_irq_vector = vec_q;
  assign irq             = irq_q;
endmodule
`default_nettype wire

/* sas_top_test.sv */
// Self-checking testbench of the converter sequencer.
`include "sas_defines.svh"
`default_nettype none
module sas_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic        ser_en = 1'b1;
  logic        wake_event = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, comp_hi_in, ana_sample, adc_power_en, cpu_clk_en, periph_clk_en, conv_irq_req, irq;
  logic [2:0]  ana_chan_sel;
  logic [9:0]  dac_code;
  logic [7:0]  conv_irq_vector;
  logic [79:0] pin_level;
  logic [7:0]  amap [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  int          lens [4] = '{1080, 810, 540, 270};
  int          n_fail = 0;
  int          n_checks = 0;
  int          n;

  always #2.5 core_clk = ~core_clk;

  sas_top dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .comp_hi_in(comp_hi_in), .serial_periph_irq_enable(ser_en), .wake_event(wake_event),
    .ana_chan_sel(ana_chan_sel), .ana_sample(ana_sample), .dac_code(dac_code), .adc_power_en(adc_power_en),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .conv_irq_req(conv_irq_req),
    .conv_irq_vector(conv_irq_vector), .irq(irq));
  sas_analog_model u_ana (.core_clk(core_clk), .pin_level(pin_level), .ana_chan_sel(ana_chan_sel),
    .ana_sample(ana_sample), .dac_code(dac_code), .adc_power_en(adc_power_en), .comp_hi_in(comp_hi_in));

  // Level of each pin, distinct per channel.
  function automatic logic [9:0] lvl(input logic [2:0] c);
    return 10'h05a + {7'h00, c} * 10'h071;
  endfunction
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) chk(32'h0, 32'h1, "no ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge core_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string what);
    xfer(1'b0, a, 8'h00);
    chk(rd, {24'h0, e}, what);
  endtask
  // Pulses the wake input and checks that all clocks and power return.
  task automatic wake;
    wake_event <= 1'b1;
    @(posedge core_clk);
    wake_event <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({cpu_clk_en, periph_clk_en, adc_power_en}, 3'b111, "wake");
  endtask
  // One conversion on channel ch at speed spd, with result and flag handling.
  task automatic conv(input logic [1:0] spd, input logic [2:0] ch);
    logic [9:0] v;
    int         k;
    v = lvl(ch);
    k = 0;
    xfer(1'b1, `SAS_ADDR_CTRL, {1'b1, spd, 2'b01, ch});
    while (conv_irq_req !== 1'b1 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    chk(k >= lens[spd] && k <= lens[spd] + 6, 1'b1, "length");
    chk(ana_chan_sel, ch, "channel");
    rc(`SAS_ADDR_RES_HI, v[9:2], "result high");
    rc(`SAS_ADDR_RES_LO, {6'h00, v[1:0]}, "result low");
    chk(irq, 1'b1, "irq done");
    ser_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(conv_irq_req, 1'b0, "shared enable");
    ser_en <= 1'b1;
    rc(`SAS_ADDR_CTRL, {1'b1, spd, 2'b10, ch}, "flag sticky, start clear");
    wr(`SAS_ADDR_STAT, 8'h01);
    wr(`SAS_ADDR_CTRL, {1'b1, spd, 2'b00, ch});
    chk({irq, conv_irq_req}, 2'b00, "cleared");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    for (int c = 0; c < 8; c++) pin_level[c*10 +: 10] = lvl(3'(c));
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (amap[i]) rc(amap[i], 8'h00, "reset value");
    chk(conv_irq_vector, 8'h2b, "vector");
    chk({cpu_clk_en, periph_clk_en, adc_power_en}, 3'b110, "reset power");
    $display("test reset done");
    wr(`SAS_ADDR_CTRL, 8'h08);
    rc(`SAS_ADDR_CTRL, 8'h00, "start unpowered");
    chk(adc_power_en, 1'b0, "power off");
    rc(`SAS_ADDR_STAT, 8'h02, "refused");
    chk(irq, 1'b0, "masked");
    wr(`SAS_ADDR_MASK, 8'h07);
    chk(irq, 1'b1, "unmasked");
    wr(`SAS_ADDR_STAT, 8'h07);
    chk(irq, 1'b0, "w1c");
    wr(8'h1c, 8'hff);
    rc(8'h1c, 8'h00, "unmapped");
    $display("test refuse done");
    wr(`SAS_ADDR_CTRL, 8'h88);
    rc(`SAS_ADDR_CTRL, 8'h88, "busy");
    chk(adc_power_en, 1'b1, "power on");
    wr(`SAS_ADDR_CTRL, 8'h88);
    rc(`SAS_ADDR_STAT, 8'h02, "busy start");
    n = 0;
    while (ana_sample !== 1'b0 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    wr(`SAS_ADDR_PWR, 8'h01);
    chk({cpu_clk_en, periph_clk_en, adc_power_en}, 3'b010, "idle");
    rc(`SAS_ADDR_CTRL, 8'h80, "abort");
    rc(`SAS_ADDR_STAT, 8'h06, "abort status");
    wake();
    rc(`SAS_ADDR_PWR, 8'h00, "woken");
    wr(`SAS_ADDR_PWR, 8'h02);
    chk({cpu_clk_en, periph_clk_en, adc_power_en}, 3'b000, "power-down");
    wake();
    wr(`SAS_ADDR_STAT, 8'h07);
    $display("test power done");
    wr(`SAS_ADDR_AUX, 8'h10);
    rc(`SAS_ADDR_AUX, 8'h10, "aux");
    wb_sel_i <= 4'he;
    wr(`SAS_ADDR_AUX, 8'h00);
    wb_sel_i <= 4'hf;
    rc(`SAS_ADDR_AUX, 8'h10, "lane 0 off");
    for (int i = 0; i < 8; i++) conv(2'(i), 3'(i));
    $display("test conversions done");
    conclude();
  end

  // Watchdog: the tests need about 6000 cycles.
  initial begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
